/* File: dv/adc_partner.sv */
// converter model on the far side of the sequencer
// assumes one start per conversion, none while busy
`timescale 1ns/1ps
`default_nettype none
module adc_partner
(
  input  wire logic                          i_ref_clk, // bench clock
  input  wire logic                          i_start,   // start pulse
  output logic                               o_done,    // done pulse
  output logic [pmon_regs_pkg::ADC_W-1:0]    o_code     // sample code
);
  int wait_n = -1; // cycles left, -1 while idle
  initial
  begin
    o_done = 1'b0;
    o_code = '0;
  end
  // random latency; code toggles while idle so stale data shows
  always @(posedge i_ref_clk)
  begin
    o_done <= 1'b0;
    o_code <= ~o_code;
    if (i_start === 1'b1)
      wait_n = $urandom_range(4, 0);
    else if (wait_n > 0)
      wait_n--;
    else if (wait_n == 0)
    begin
      o_done <= 1'b1;
      o_code <= pmon_regs_pkg::ADC_W'($urandom);
      wait_n = -1;
    end
  end
endmodule // adc_partner
`default_nettype wire

/* File: dv/pmon_props.sv */
// checker on the command, run and pin ports of the monitor
// assumes reset is released on a rising clock edge
`timescale 1ns/1ps
`default_nettype none
module pmon_props
(
  input wire logic        i_ref_clk,          // clock
  input wire logic        i_nrst,             // reset
  input wire logic        i_cmd_strobe,       // strobe
  input wire logic        i_cmd_write,        // write
  input wire logic        i_cmd_word,         // word
  input wire logic [7:0]  i_cmd_code,         // code
  input wire logic [15:0] i_cmd_wdata,        // data
  input wire logic        i_conv_done,        // done
  input wire logic [15:0] o_rsp_rdata,        // read
  input wire logic        o_conv_start,       // start
  input wire logic        o_range_high,       // span
  input wire logic        o_monitor_busy,     // run
  input wire logic        o_second_output_pin // pin
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);
  // decoded accesses
  wire logic rd2 = i_cmd_strobe && !i_cmd_write && i_cmd_code == 8'hD2;
  wire logic rd3 = i_cmd_strobe && !i_cmd_write && i_cmd_code == 8'hD3;
  wire logic bw  = i_cmd_strobe && i_cmd_write && !i_cmd_word;
  wire logic bw3 = bw && i_cmd_code == 8'hD3;
  wire logic bw4 = bw && i_cmd_code == 8'hD4;
  property p_peak_hi; rd2 && i_cmd_word |=> o_rsp_rdata[15:12] == 4'h0;
  endproperty
  a_peak_hi: assert property (p_peak_hi) else $error("peak top");
  property p_run_hi; rd3 && !i_cmd_word |=> o_rsp_rdata[15:1] == 15'h0000;
  endproperty
  a_run_hi: assert property (p_run_hi) else $error("run top set");
  property p_idle; !o_monitor_busy && !$past(o_monitor_busy) |->
    !o_conv_start; endproperty
  a_idle: assert property (p_idle) else $error("start stopped");
  property p_pulse; o_conv_start |=> !o_conv_start; endproperty
  a_pulse: assert property (p_pulse) else $error("start too long");
  property p_stop; bw3 && !i_cmd_wdata[0] |=> !o_monitor_busy; endproperty
  a_stop: assert property (p_stop) else $error("run not cleared");
  property p_span; bw4 |=> o_range_high == $past(i_cmd_wdata[5]); endproperty
  a_span: assert property (p_span) else $error("span bit wrong");
  property p_self; $fell(o_monitor_busy) |-> $past(i_conv_done) || $past(bw3);
  endproperty
  a_self: assert property (p_self) else $error("bad run clear");
  property p_rst; $rose(i_nrst) |-> o_monitor_busy && o_range_high;
  endproperty
  a_rst: assert property (p_rst) else $error("reset value wrong");
  property p_pin; $rose(i_nrst) |-> o_second_output_pin; endproperty
  a_pin: assert property (p_pin) else $error("pin asserted");
  cover property ($fell(o_monitor_busy));
  cover property (rd2);
  cover property (o_conv_start);
endmodule // pmon_props
bind power_monitor_alert_config pmon_props pmon_props_inst (.*);
`default_nettype wire

/* File: dv/test_power_monitor_alert_config.sv */
// self-checking bench: registers, alert pin, averaging
// assumes partner and checker are compiled with it
`timescale 1ns/1ps
`default_nettype none
module test_power_monitor_alert_config;
  logic        clk = 1'b0, nrst = 1'b0, stb = 1'b0, wr = 1'b0, wd = 1'b0;
  logic [7:0]  code = 8'h00;
  logic [15:0] wdat = 16'h0000, q;
  logic [6:0]  flags = 7'h00;
  logic [11:0] ccode, iv, ic, ov;
  logic [1:0]  ch;
  logic        vld, nk, start, rng, busy, pin, done;
  int          n_fail = 0, compares = 0, sums[3], cnt[3], pk, m;
  always #10 clk = ~clk;
  power_monitor_alert_config power_monitor_alert_config_inst (
    .i_ref_clk(clk), .i_nrst(nrst), .i_cmd_strobe(stb), .i_cmd_write(wr),
    .i_cmd_word(wd), .i_cmd_code(code), .i_cmd_wdata(wdat), .o_rsp_valid(vld),
    .o_rsp_nack(nk), .o_rsp_rdata(q), .o_conv_start(start), .o_conv_channel(ch),
    .o_range_high(rng), .i_conv_done(done), .i_conv_code(ccode),
    .o_input_voltage(iv), .o_load_current(ic), .o_output_voltage(ov),
    .o_monitor_busy(busy), .i_status_flags(flags), .o_second_output_pin(pin));
  adc_partner adc_partner_inst (.i_ref_clk(clk), .i_start(start),
    .o_done(done), .o_code(ccode));
  // reference sums per channel
  always @(posedge clk)
    if (nrst && done === 1'b1)
    begin
      sums[ch] += ccode;
      cnt[ch]++;
    end
  task automatic chk(input logic [15:0] got, exp);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected %0t got %h want %h", $time, got, exp);
    end
  endtask
  // one command, f = {write, word, nack}, answer the cycle after strobe
  task automatic acc(input logic [2:0] f, input logic [7:0] c,
                     input logic [15:0] d, e);
    @(posedge clk);
    stb <= 1'b1; wr <= f[2]; wd <= f[1]; code <= c; wdat <= d;
    @(posedge clk);
    stb <= 1'b0;
    #1;
    chk({vld, nk}, {1'b1, f[0]});
    if (!f[2] && !f[0]) chk(q, e);
  endtask
  task automatic results();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    void'($urandom(73323));
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    acc(3'h2, 8'hD2, '0, '0);
    acc(3'h0, 8'hD3, '0, 16'h0001);
    acc(3'h0, 8'hD4, '0, 16'h00AF);
    acc(3'h2, 8'hD6, '0, 16'h8000);
    acc(3'h3, 8'hD3, '0, '0);
    acc(3'h4, 8'hD3, '0, '0);
    acc(3'h0, 8'hD3, '0, '0);
    $display("reset values and stop done");
    for (int i = 0; i < 8; i++)
    begin
      m = ($urandom & 32'hFE00) | (i & 3); // bit 1 picks the gpio function
      acc(3'h6, 8'hD6, m[15:0], '0);
      acc(3'h2, 8'hD6, '0, m[15:0]);
      @(posedge clk);
      flags <= 7'($urandom);
      repeat (4) @(posedge clk);
      chk(pin, m[1] ? m[0] : (|(flags & m[15:9])) == m[0]);
    end
    $display("alert pin done");
    pk = 0;
    for (int a = 0; a < 8; a++)
    begin
      m = 32'h48 | a | ($urandom & 32'h20);
      acc(3'h4, 8'hD4, m[15:0], '0);
      acc(3'h0, 8'hD4, '0, m[15:0]);
      sums = '{0, 0, 0};
      cnt = '{0, 0, 0};
      acc(3'h4, 8'hD3, 16'h0001, '0);
      for (int t = 0; t < 3000 && busy === 1'b1; t++) @(posedge clk);
      repeat (4) @(posedge clk);
      chk(16'(cnt[2]), 16'(1 << a));
      chk(iv, 16'(sums[0] >> a));
      chk(ic, 16'(sums[1] >> a));
      chk(ov, 16'(sums[2] >> a));
      if ((sums[2] >> a) > pk) pk = sums[2] >> a;
      acc(3'h2, 8'hD2, '0, 16'(pk));
      chk(rng, m[5]);
      chk(busy, 1'b0);
    end
    acc(3'h6, 8'hD2, '0, '0);
    acc(3'h2, 8'hD2, '0, '0);
    $display("averaging done");
    results();
  end
  // watchdog: tests need about 5000 cycles
  initial
  begin
    repeat (40000) @(posedge clk);
    n_fail++;
    results();
  end
endmodule // test_power_monitor_alert_config
`default_nettype wire

/* File: rtl/pmon_regs_pkg.sv */
// constants for the power monitor command registers and sequencer
// assumes command codes are decoded outside
package pmon_regs_pkg;

  // command codes of the four registers
  localparam logic [7:0]  CMD_PEAK_HOLD      = 8'hD2;
  localparam logic [7:0]  CMD_RUN_CONTROL    = 8'hD3;
  localparam logic [7:0]  CMD_MONITOR_SETUP  = 8'hD4;
  localparam logic [7:0]  CMD_SECOND_MASK    = 8'hD6;

  // reset values
  localparam logic [15:0] RST_PEAK_HOLD      = 16'h0000;
  localparam logic [7:0]  RST_RUN_CONTROL    = 8'h01;
  localparam logic [7:0]  RST_MONITOR_SETUP  = 8'hAF;
  localparam logic [15:0] RST_SECOND_MASK    = 16'h8000;

  // peak clear value and code widths
  localparam logic [15:0] PEAK_CLEAR_VALUE   = 16'h0000;
  localparam int          ADC_W              = 12;
  localparam int          ACC_W              = 19;

  // field positions
  localparam int          RUN_BIT            = 0;
  localparam int          SETUP_MODE_BIT     = 7;
  localparam int          SETUP_OUTV_BIT     = 6;
  localparam int          SETUP_RANGE_BIT    = 5;
  localparam int          SETUP_AVG_LSB      = 0;
  localparam int          AVG_W              = 3;
  localparam int          MASK_FLAG_LSB      = 9;
  localparam int          NUM_FLAGS          = 7;
  localparam int          MASK_FUNC_LSB      = 1;
  localparam int          MASK_POL_BIT       = 0;

  // second output pin functions
  localparam logic [1:0]  FUNC_ALERT         = 2'h0;
  localparam logic [1:0]  FUNC_GPIO          = 2'h1;

  // conversion channels
  localparam logic [1:0]  CH_INV             = 2'h0;
  localparam logic [1:0]  CH_CUR             = 2'h1;
  localparam logic [1:0]  CH_OUTV            = 2'h2;

  // sample counter, up to 128
  localparam int          CNT_W              = 8;
  localparam logic [7:0]  CNT_ONE            = 8'h01;

  // sequencer states
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_ISSUE = 2'b01,
    ST_WAIT  = 2'b10
  } seq_state_e;

endpackage

/* File: rtl/pmon_sample_averager.sv */
// running sum of adc codes for one channel, mean out of a register
// assumes a channel's codes arrive back to back
`timescale 1ns/1ps
`default_nettype none

module pmon_sample_averager
(
  input  wire logic                               i_ref_clk, // clock
  input  wire logic                               i_rst_n,   // synced rst
  input  wire logic                               i_flush,   // drop sum
  input  wire logic                               i_add,     // code valid
  input  wire logic                               i_last,    // final one
  input  wire logic [pmon_regs_pkg::ADC_W-1:0]    i_code,    // adc code
  input  wire logic [pmon_regs_pkg::AVG_W-1:0]    i_shift,   // log2 depth
  output logic      [pmon_regs_pkg::ADC_W-1:0]    o_mean,    // averaged
  output logic                                    o_valid    // mean pulse
);

  ////////////////////////////////////////////////////////////////////////
  // sum and divide by shifting; depth is a power of two so no divider
  logic [pmon_regs_pkg::ACC_W-1:0] acc_r;     // running sum
  logic [pmon_regs_pkg::ADC_W-1:0] mean_r;    // last mean
  logic                            valid_r;   // mean strobe
  wire  [pmon_regs_pkg::ACC_W-1:0] sum_w;     // sum with new code
  wire  [pmon_regs_pkg::ACC_W-1:0] shifted_w; // sum over depth

  assign sum_w     = acc_r + {{(pmon_regs_pkg::ACC_W
                     - pmon_regs_pkg::ADC_W){1'b0}}, i_code};
  assign shifted_w = sum_w >> i_shift;

  ////////////////////////////////////////////////////////////////////////
  // accumulator; restarts after last sample or flush
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      acc_r   <= '0;
      mean_r  <= '0;
      valid_r <= 1'b0;
    end
    else
    begin
      valid_r <= i_add && i_last && !i_flush;
      if (i_flush)
        acc_r <= '0;                      // aborted cycle, drop partials
      else if (i_add && i_last)
      begin
        acc_r  <= '0;
        mean_r <= shifted_w[pmon_regs_pkg::ADC_W-1:0]; // [RULE13]
      end
      else if (i_add)
        acc_r <= sum_w;
    end
  end

  assign o_mean  = mean_r;
  assign o_valid = valid_r;

endmodule // pmon_sample_averager

`default_nettype wire

/* File: rtl/power_monitor_alert_config.sv */
// command registers and sampling sequencer of the power monitor
// assumes a bus engine hands over decoded commands, and an adc that
// answers each start with one done pulse carrying a 12-bit code
//
// What this block does
// RULE1 - peak register holds highest output-voltage code
// RULE2 - word write zero clears peak; resets zero
// RULE3 - peak upper four bits read zero
// RULE4 - run bit starts sampling; upper bits zero
// RULE5 - single-shot clears run bit after cycle
// RULE6 - continuous keeps sampling until host writes zero
// RULE7 - run-control resets to one
// RULE8 - host stops monitor before changing setup
// RULE9 - setup bit 7 selects single or continuous
// RULE10 - setup bit 6 adds output-voltage sampling
// RULE11 - setup bit 5 selects low/high range
// RULE12 - host writes bit4 zero, bit3 one
// RULE13 - averaging field sets depth, 1 to 128
// RULE14 - setup resets to 0xAF defaults
// RULE15 - mask bit 15 enables switch-damage alert
// RULE16 - mask bit 14 enables overcurrent fault alert
// RULE17 - mask bit 13 enables input overvoltage alert
// RULE18 - mask bit 12 enables input undervoltage alert
// RULE19 - mask bit 11 enables comm/logic error alert
// RULE20 - mask bit 10 enables overcurrent warning alert
// RULE21 - mask bit 9 enables secondary current alert
// RULE22 - second mask resets to 0x8000
// RULE23 - default function makes pin the alert
// RULE24 - polarity zero active low, one high
// RULE25 - alert is OR of enabled flags
`timescale 1ns/1ps
`default_nettype none

module power_monitor_alert_config
(
  input  wire logic                               i_ref_clk,      // 50 MHz
  input  wire logic                               i_nrst,         // async
  // decoded command from the bus engine
  input  wire logic                               i_cmd_strobe,   // pulse
  input  wire logic                               i_cmd_write,    // 1=write
  input  wire logic                               i_cmd_word,     // 1=word
  input  wire logic [7:0]                         i_cmd_code,     // code
  input  wire logic [15:0]                        i_cmd_wdata,    // data
  output logic                                    o_rsp_valid,    // pulse
  output logic                                    o_rsp_nack,     // refuse
  output logic [15:0]                             o_rsp_rdata,    // read
  // adc side
  output logic                                    o_conv_start,   // pulse
  output logic [1:0]                              o_conv_channel, // chan
  output logic                                    o_range_high,   // span
  input  wire logic                               i_conv_done,    // pulse
  input  wire logic [pmon_regs_pkg::ADC_W-1:0]    i_conv_code,    // code
  // averaged results
  output logic [pmon_regs_pkg::ADC_W-1:0]         o_input_voltage,
  output logic [pmon_regs_pkg::ADC_W-1:0]         o_load_current,
  output logic [pmon_regs_pkg::ADC_W-1:0]         o_output_voltage,
  output logic                                    o_monitor_busy, // level
  // status flags 15..9 order and the pin
  input  wire logic [pmon_regs_pkg::NUM_FLAGS-1:0] i_status_flags,
  output logic                                    o_second_output_pin
);

  ////////////////////////////////////////////////////////////////////////
  // reset release through two flops
  logic rst_meta_r;  // first stage, read only by the second
  logic rst_n_s;     // synchronised reset used everywhere

  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      rst_meta_r <= 1'b0;
      rst_n_s    <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_n_s    <= rst_meta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registers
  logic [pmon_regs_pkg::ADC_W-1:0] peak_r;    // captured peak code
  logic                            run_r;     // run bit
  logic [7:0]                      setup_r;   // monitor setup
  logic [15:0]                     mask_r;    // second alert mask

  // setup fields
  wire                             continuous_w; // repeat sampling
  wire                             outv_inc_w;   // include output volts
  wire [pmon_regs_pkg::AVG_W-1:0]  avg_w;        // log2 averaging depth

  assign continuous_w = setup_r[pmon_regs_pkg::SETUP_MODE_BIT]; // [RULE9]
  assign outv_inc_w   = setup_r[pmon_regs_pkg::SETUP_OUTV_BIT]; // [RULE10]
  assign avg_w        = setup_r[pmon_regs_pkg::SETUP_AVG_LSB +:
                                pmon_regs_pkg::AVG_W];

  ////////////////////////////////////////////////////////////////////////
  // command decode
  wire hit_peak_w;   // peak register addressed
  wire hit_run_w;    // run-control addressed
  wire hit_setup_w;  // setup addressed
  wire hit_mask_w;   // mask addressed
  wire size_ok_w;    // byte or word matches the register
  wire accept_w;     // command taken
  wire wr_w;         // accepted write
  wire wr_peak_zero_w; // clearing write to the peak

  assign hit_peak_w  = i_cmd_code == pmon_regs_pkg::CMD_PEAK_HOLD;
  assign hit_run_w   = i_cmd_code == pmon_regs_pkg::CMD_RUN_CONTROL;
  assign hit_setup_w = i_cmd_code == pmon_regs_pkg::CMD_MONITOR_SETUP;
  assign hit_mask_w  = i_cmd_code == pmon_regs_pkg::CMD_SECOND_MASK;
  assign size_ok_w   = ((hit_peak_w || hit_mask_w) && i_cmd_word)
                    || ((hit_run_w || hit_setup_w) && !i_cmd_word);
  assign accept_w    = i_cmd_strobe && size_ok_w;
  assign wr_w        = accept_w && i_cmd_write;
  // a nonzero word to the peak is taken but changes nothing
  assign wr_peak_zero_w = wr_w && hit_peak_w
                       && (i_cmd_wdata == pmon_regs_pkg::PEAK_CLEAR_VALUE);

  // read mux; reserved bits are zero
  wire [15:0] rdata_w;
  assign rdata_w =
      hit_peak_w  ? {{(16 - pmon_regs_pkg::ADC_W){1'b0}}, peak_r} // [RULE3]
    : hit_run_w   ? {15'h0000, run_r}                             // [RULE4]
    : hit_setup_w ? {8'h00, setup_r}
    : hit_mask_w  ? mask_r
    : 16'h0000;

  ////////////////////////////////////////////////////////////////////////
  // response one cycle after the strobe; unknown or missized is a nack
  logic        rsp_valid_r;  // answer strobe
  logic        rsp_nack_r;   // refused
  logic [15:0] rsp_rdata_r;  // read data

  always_ff @(posedge i_ref_clk or negedge rst_n_s)
  begin
    if (!rst_n_s)
    begin
      rsp_valid_r <= 1'b0;
      rsp_nack_r  <= 1'b0;
      rsp_rdata_r <= 16'h0000;
    end
    else
    begin
      rsp_valid_r <= i_cmd_strobe;
      rsp_nack_r  <= i_cmd_strobe && !size_ok_w;
      if (accept_w && !i_cmd_write)
        rsp_rdata_r <= rdata_w;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sequencer signals
  pmon_regs_pkg::seq_state_e state_r;   // sequencer state
  logic [1:0]                chan_r;    // channel in conversion
  logic [pmon_regs_pkg::CNT_W-1:0] cnt_r; // samples done on channel
  logic                      start_r;   // adc start pulse
  wire [pmon_regs_pkg::CNT_W-1:0] depth_w; // samples per channel
  wire                       last_w;    // final sample of channel
  wire                       last_ch_w; // final channel of cycle
  wire                       cycle_end_w; // whole cycle done
  wire                       flush_w;   // abandon the cycle
  wire [1:0]                 next_ch_w; // following channel

  assign depth_w   = pmon_regs_pkg::CNT_ONE << avg_w;          // [RULE13]
  assign last_w    = (cnt_r == depth_w - pmon_regs_pkg::CNT_ONE);
  assign last_ch_w = outv_inc_w ? (chan_r == pmon_regs_pkg::CH_OUTV)
                                : (chan_r == pmon_regs_pkg::CH_CUR);
  assign next_ch_w = (chan_r == pmon_regs_pkg::CH_INV)
                   ? pmon_regs_pkg::CH_CUR : pmon_regs_pkg::CH_OUTV;
  assign cycle_end_w = (state_r == pmon_regs_pkg::ST_WAIT) && i_conv_done
                    && last_w && last_ch_w;
  assign flush_w   = !run_r && (state_r != pmon_regs_pkg::ST_IDLE);

  ////////////////////////////////////////////////////////////////////////
  // run bit; a host write wins over the self-clear in the same cycle
  always_ff @(posedge i_ref_clk or negedge rst_n_s)
  begin
    if (!rst_n_s)                                          // [RULE7]
      run_r <= pmon_regs_pkg::RST_RUN_CONTROL[pmon_regs_pkg::RUN_BIT];
    else if (wr_w && hit_run_w)
      run_r <= i_cmd_wdata[pmon_regs_pkg::RUN_BIT];        // [RULE4] [RULE6]
    else if (cycle_end_w && !continuous_w)
      run_r <= 1'b0;                                       // [RULE5]
  end

  ////////////////////////////////////////////////////////////////////////
  // setup and mask, plain read/write
  always_ff @(posedge i_ref_clk or negedge rst_n_s)
  begin
    if (!rst_n_s)
    begin
      setup_r <= pmon_regs_pkg::RST_MONITOR_SETUP;         // [RULE14]
      mask_r  <= pmon_regs_pkg::RST_SECOND_MASK;           // [RULE22]
    end
    else
    begin
      // no guard against changes while sampling; caller must stop first
      if (wr_w && hit_setup_w)
        setup_r <= i_cmd_wdata[7:0];                       // [RULE11]
      if (wr_w && hit_mask_w)
        mask_r  <= i_cmd_wdata;                            // [RULE17]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sequencer: each channel gets depth conversions, then the next
  always_ff @(posedge i_ref_clk or negedge rst_n_s)
  begin
    if (!rst_n_s)
    begin
      state_r <= pmon_regs_pkg::ST_IDLE;
      chan_r  <= pmon_regs_pkg::CH_INV;
      cnt_r   <= '0;
      start_r <= 1'b0;
    end
    else
    begin
      start_r <= 1'b0;
      case (state_r)
        pmon_regs_pkg::ST_IDLE:
        begin
          chan_r <= pmon_regs_pkg::CH_INV;
          cnt_r  <= '0;
          if (run_r)
            state_r <= pmon_regs_pkg::ST_ISSUE;            // [RULE4]
        end
        pmon_regs_pkg::ST_ISSUE:
        begin
          if (!run_r)
            state_r <= pmon_regs_pkg::ST_IDLE;
          else
          begin
            start_r <= 1'b1;
            state_r <= pmon_regs_pkg::ST_WAIT;
          end
        end
        pmon_regs_pkg::ST_WAIT:
        begin
          // a stop abandons the conversion in flight
          if (!run_r)
            state_r <= pmon_regs_pkg::ST_IDLE;             // [RULE6]
          else if (i_conv_done)
          begin
            if (!last_w)
            begin
              cnt_r   <= cnt_r + pmon_regs_pkg::CNT_ONE;
              state_r <= pmon_regs_pkg::ST_ISSUE;
            end
            else if (!last_ch_w)
            begin
              cnt_r   <= '0;
              chan_r  <= next_ch_w;
              state_r <= pmon_regs_pkg::ST_ISSUE;
            end
            else
            begin
              cnt_r   <= '0;
              chan_r  <= pmon_regs_pkg::CH_INV;
              // single shot drops to idle as the run bit clears
              state_r <= continuous_w ? pmon_regs_pkg::ST_ISSUE
                                      : pmon_regs_pkg::ST_IDLE; // [RULE5]
            end
          end
        end
        default:
          state_r <= pmon_regs_pkg::ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // averager shared by all channels, they never overlap
  wire [pmon_regs_pkg::ADC_W-1:0] mean_w;   // averaged code
  wire                            mean_vld_w; // mean strobe
  logic [1:0]                     res_ch_r; // channel of pending mean
  wire                            add_w;    // sample taken

  assign add_w = (state_r == pmon_regs_pkg::ST_WAIT) && i_conv_done && run_r;

  pmon_sample_averager u_avg
  (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (rst_n_s),
    .i_flush   (flush_w),
    .i_add     (add_w),
    .i_last    (last_w),
    .i_code    (i_conv_code),
    .i_shift   (avg_w),
    .o_mean    (mean_w),
    .o_valid   (mean_vld_w)
  );

  ////////////////////////////////////////////////////////////////////////
  // result registers and peak capture
  logic [pmon_regs_pkg::ADC_W-1:0] inv_r;   // input voltage result
  logic [pmon_regs_pkg::ADC_W-1:0] cur_r;   // load current result
  logic [pmon_regs_pkg::ADC_W-1:0] outv_r;  // output voltage result
  wire                             outv_new_w; // fresh output volts

  assign outv_new_w = mean_vld_w && (res_ch_r == pmon_regs_pkg::CH_OUTV);

  always_ff @(posedge i_ref_clk or negedge rst_n_s)
  begin
    if (!rst_n_s)                                          // [RULE2]
    begin
      res_ch_r <= pmon_regs_pkg::CH_INV;
      inv_r    <= '0;
      cur_r    <= '0;
      outv_r   <= '0;
      peak_r   <= pmon_regs_pkg::RST_PEAK_HOLD[pmon_regs_pkg::ADC_W-1:0];
    end
    else
    begin
      if (add_w)
        res_ch_r <= chan_r;
      if (mean_vld_w && (res_ch_r == pmon_regs_pkg::CH_INV))
        inv_r <= mean_w;
      if (mean_vld_w && (res_ch_r == pmon_regs_pkg::CH_CUR))
        cur_r <= mean_w;
      if (outv_new_w)
        outv_r <= mean_w;
      // a mean beside a clear is kept as the first since clearing
      if (wr_peak_zero_w)
        peak_r <= outv_new_w ? mean_w : '0;                // [RULE2]
      else if (outv_new_w && (mean_w > peak_r))
        peak_r <= mean_w;                                  // [RULE1]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // second output pin
  second_pin_driver u_pin
  (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (rst_n_s),
    .i_flags   (i_status_flags),
    .i_enables (mask_r[pmon_regs_pkg::MASK_FLAG_LSB +:
                       pmon_regs_pkg::NUM_FLAGS]),   // [RULE18] [RULE19]
    .i_func    (mask_r[pmon_regs_pkg::MASK_FUNC_LSB +: 2]), // [RULE20]
    .i_pol     (mask_r[pmon_regs_pkg::MASK_POL_BIT]),       // [RULE21]
    .o_pin     (o_second_output_pin)
  );

  ////////////////////////////////////////////////////////////////////////
  // outputs, all from flops
  assign o_rsp_valid      = rsp_valid_r;
  assign o_rsp_nack       = rsp_nack_r;
  assign o_rsp_rdata      = rsp_rdata_r;
  assign o_conv_start     = start_r;
  assign o_conv_channel   = chan_r;
  assign o_range_high     = setup_r[pmon_regs_pkg::SETUP_RANGE_BIT];
  assign o_input_voltage  = inv_r;
  assign o_load_current   = cur_r;
  assign o_output_voltage = outv_r;
  assign o_monitor_busy   = run_r;

endmodule // power_monitor_alert_config

`default_nettype wire

/* File: rtl/second_pin_driver.sv */
// drives the second output pin from masked status flags
// assumes flags are already sticky in the status logic outside
`timescale 1ns/1ps
`default_nettype none

module second_pin_driver
(
  input  wire logic                                 i_ref_clk, // clock
  input  wire logic                                 i_rst_n,   // synced
  input  wire logic [pmon_regs_pkg::NUM_FLAGS-1:0]  i_flags,   // status
  input  wire logic [pmon_regs_pkg::NUM_FLAGS-1:0]  i_enables, // mask
  input  wire logic [1:0]                           i_func,    // function
  input  wire logic                                 i_pol,     // 1 = high
  output logic                                      o_pin      // pin level
);

  ////////////////////////////////////////////////////////////////////////
  // per-flag gating, one generate loop
  wire [pmon_regs_pkg::NUM_FLAGS-1:0] gated_w;   // enabled flags
  wire                                alert_w;   // any enabled flag
  wire                                active_w;  // pin asserted
  wire                                level_w;   // pin level to drive
  logic                               pin_r;     // registered pin

  genvar g;
  generate
    for (g = 0; g < pmon_regs_pkg::NUM_FLAGS; g = g + 1)
    begin : g_gate
      assign gated_w[g] = i_flags[g] & i_enables[g]; // [RULE15] [RULE16]
    end
  endgenerate

  // or of all enabled sources
  assign alert_w  = |gated_w;                              // [RULE25]
  // comparator and reserved functions give the idle level
  assign active_w = (i_func == pmon_regs_pkg::FUNC_ALERT) ? alert_w
                    : 1'b0;                                // [RULE23]
  // gpio function drives the polarity bit
  assign level_w  = (i_func == pmon_regs_pkg::FUNC_GPIO) ? i_pol
                    : (i_pol ? active_w : ~active_w);      // [RULE24]

  ////////////////////////////////////////////////////////////////////////
  // pin flop; resets deasserted for the default polarity
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      pin_r <= 1'b1;
    else
      pin_r <= level_w;
  end

  assign o_pin = pin_r;

endmodule // second_pin_driver

`default_nettype wire
